// ---- tcr_pkg.sv ----
// Package with constants and types for the touch controller reset logic
package tcr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 20000;
    localparam int RST_MIN_NS        = 10000;
    localparam int RST_REJECT_NS     = 5000;
    localparam int SPIKE_NS          = 20;
    localparam int RST_MIN_CYC       = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_REJECT_CYC    = (RST_REJECT_NS * 1000) / CLK_PERIOD_PS;
    localparam int SPIKE_CYC_RAW     = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SPIKE_CYC         = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    localparam int CNT_W             = 10;
    localparam int FILT_W            = 3;

    // ------------------------------------------------------------
    // Field positions, widths, reset values and reset hold time
    // ------------------------------------------------------------
    localparam int SOFT_RESET_POS    = 1;
    localparam int CTRL_BYTE_W       = 8;
    localparam int RESULT_W          = 16;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam int HOLD_CYC          = 4;

    typedef enum logic [1:0] {
        ST_POR,
        ST_RESET,
        ST_RUN
    } tcr_state_type;

endpackage : tcr_pkg

// ---- tcr_if.sv ----
// Interface carrying the filtered reset pin between the filter and the top
`timescale 1ns/10ps
interface tcr_filt_if;
    logic pinLevel;
    logic lowStart;
    modport filt (output pinLevel, output lowStart);
    modport user (input pinLevel, input lowStart);
endinterface : tcr_filt_if

// ---- tcr_spike_filter.sv ----
// Synchroniser and spike filter for the external reset pin
`timescale 1ns/10ps
module tcr_spike_filter
    import tcr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    tcr_filt_if.filt  filt
);
    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic [FILT_W-1:0] run;
        logic             level;
        logic             lowStart;
    } tcr_filt_state_type;

    tcr_filt_state_type st_ff;
    tcr_filt_state_type nxt_st;

    // ------------------------------------------------------------
    // Spike rejection: level must hold past the spike width to count
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.sync1    = pinIn;
        nxt_st.sync2    = st_ff.sync1;
        nxt_st.lowStart = 1'b0;
        if (st_ff.sync2 == st_ff.level)
        begin
            nxt_st.run = '0;
        end
        else if (st_ff.run >= FILT_W'(SPIKE_CYC))
        begin
            nxt_st.level    = st_ff.sync2;
            nxt_st.run      = '0;
            nxt_st.lowStart = ~st_ff.sync2;
        end
        else
        begin
            nxt_st.run = st_ff.run + FILT_W'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_ff <= '{sync1: 1'b1, sync2: 1'b1, run: '0, level: 1'b1, lowStart: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign filt.pinLevel = st_ff.level;
    assign filt.lowStart = st_ff.lowStart;
endmodule : tcr_spike_filter

// ---- tcr_reset_logic.sv ----
// Reset sequencer of the touch controller: power-on, pin and soft reset
// How it works
// - Power-on, reset pin or soft reset bit all return the device to defaults.
// - Power-on reset clears state machine, registers and output pins.
// - Pin low for 10 us or more resets the device; the code needs more than MIN_CYC cycles low.
// - Pin low pulses shorter than 5 us are ignored.
// - Spikes up to 20 ns are filtered before width qualification.
// - Writing 1 to bit D1 of control byte 1 resets the device.
// - Interrupt output is active low, data ready or pen touch.
// - Reset pin is active low; high allows normal operation.
// - Two strap pins give address bits 0 and 1.
// - Conversion result registers read zero after any reset until written.
`timescale 1ns/10ps
module tcr_reset_logic
    import tcr_pkg::*;
#(
    parameter int MIN_CYC    = RST_MIN_CYC,
    parameter int HOLD       = HOLD_CYC
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   resetPin_n,
    input  wire logic                   addrStrapLsb,
    input  wire logic                   addrStrapMsb,
    input  wire logic                   ctrlByte1Wr,
    input  wire logic [CTRL_BYTE_W-1:0] ctrlByte1Data,
    input  wire logic                   dataReady,
    input  wire logic                   penTouchIrq,
    input  wire logic                   irqSelPen,
    input  wire logic                   resultWr,
    input  wire logic [RESULT_W-1:0]    resultData,
    output logic                        deviceReset,
    output logic                        irqOrDataReady_n,
    output logic [1:0]                  slaveAddrLow,
    output logic [RESULT_W-1:0]         resultReg
);
    import tcr_pkg::*;

    typedef struct packed {
        tcr_state_type       state;
        logic [CNT_W-1:0]    lowCnt;
        logic                qualified;
        logic [CNT_W-1:0]    holdCnt;
        logic                strapA;
        logic                strapB;
        logic [1:0]          addr;
        logic                devRst;
        logic                irq_n;
        logic [RESULT_W-1:0] result;
    } tcr_top_state_type;

    tcr_top_state_type st_ff;
    tcr_top_state_type nxt_st;
    tcr_filt_if        filtBus ();
    logic              softReq;
    logic              pinReq;

    tcr_spike_filter u_filter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pinIn   (resetPin_n),
        .filt    (filtBus.filt)
    );

    // ------------------------------------------------------------
    // Reset requests
    // ------------------------------------------------------------
    assign softReq = ctrlByte1Wr && ctrlByte1Data[SOFT_RESET_POS];
    // Short pulses never reach MIN_CYC, so anything under 5 us is dropped
    assign pinReq  = st_ff.qualified;

    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.strapA = addrStrapLsb;
        nxt_st.strapB = addrStrapMsb;
        // Width counter runs while the filtered pin is low
        if (filtBus.pinLevel)
        begin
            nxt_st.lowCnt    = '0;
            nxt_st.qualified = 1'b0;
        end
        else if (filtBus.lowStart)
        begin
            nxt_st.lowCnt    = CNT_W'(1);
            nxt_st.qualified = 1'b0;
        end
        else if (st_ff.lowCnt >= CNT_W'(MIN_CYC))
        begin
            nxt_st.qualified = 1'b1;
        end
        else
        begin
            nxt_st.lowCnt = st_ff.lowCnt + CNT_W'(1);
        end

        case (st_ff.state)
            ST_POR, ST_RESET:
            begin
                nxt_st.devRst = 1'b1;
                nxt_st.irq_n  = 1'b1;
                nxt_st.result = RESULT_RST;
                if (pinReq)
                begin
                    nxt_st.holdCnt = '0;
                end
                else if (st_ff.holdCnt >= CNT_W'(HOLD))
                begin
                    nxt_st.state  = ST_RUN;
                    nxt_st.devRst = 1'b0;
                    // Straps are caught as the reset releases
                    nxt_st.addr   = {st_ff.strapB, st_ff.strapA};
                end
                else
                begin
                    nxt_st.holdCnt = st_ff.holdCnt + CNT_W'(1);
                end
            end
            default:
            begin
                nxt_st.devRst = 1'b0;
                nxt_st.irq_n  = ~(irqSelPen ? penTouchIrq : dataReady);
                if (resultWr)
                begin
                    nxt_st.result = resultData;
                end
                if (pinReq || softReq)
                begin
                    nxt_st.state   = ST_RESET;
                    nxt_st.holdCnt = '0;
                    nxt_st.devRst  = 1'b1;
                    nxt_st.irq_n   = 1'b1;
                    nxt_st.result  = RESULT_RST;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register; rst_n stands in for the power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_ff <= '{state: ST_POR, lowCnt: '0, qualified: 1'b0, holdCnt: '0,
                       strapA: 1'b0, strapB: 1'b0, addr: 2'h0, devRst: 1'b1,
                       irq_n: 1'b1, result: RESULT_RST};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign deviceReset      = st_ff.devRst;
    assign irqOrDataReady_n = st_ff.irq_n;
    assign slaveAddrLow     = st_ff.addr;
    assign resultReg        = st_ff.result;
endmodule : tcr_reset_logic

// ---- tcr_reset_props.sv ----
// Port checker of the reset sequencer
`timescale 1ns/10ps
module tcr_reset_props
    import tcr_pkg::*;
#(
    parameter int MIN_CYC = 20
)
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        resetPin_n,
    input wire logic        addrStrapLsb,
    input wire logic        addrStrapMsb,
    input wire logic        ctrlByte1Wr,
    input wire logic [7:0]  ctrlByte1Data,
    input wire logic        dataReady,
    input wire logic        penTouchIrq,
    input wire logic        irqSelPen,
    input wire logic        deviceReset,
    input wire logic        irqOrDataReady_n,
    input wire logic [1:0]  slaveAddrLow,
    input wire logic [15:0] resultReg
);
    logic [9:0] lowCnt_ff;
    // Saturates so a pin stuck low cannot wrap back below the threshold
    always_ff @(posedge ref_clk)
    begin
        lowCnt_ff <= resetPin_n ? 10'h000 : lowCnt_ff + 10'(lowCnt_ff != 10'h3ff);
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    rst_defaults_a: assert property ($rose(rst_n) |-> deviceReset && irqOrDataReady_n
        && slaveAddrLow == 2'h0 && resultReg == 16'h0000) else $error("bad state at release");
    soft_reset_a: assert property (ctrlByte1Wr && ctrlByte1Data[1] && !deviceReset
        |=> deviceReset) else $error("soft reset not taken");
    irq_quiet_a: assert property (deviceReset && $past(deviceReset)
        |-> irqOrDataReady_n) else $error("irq low in reset");
    result_clear_a: assert property (deviceReset && $past(deviceReset)
        |-> resultReg == 16'h0000) else $error("result not cleared");
    hold_release_a: assert property ($fell(deviceReset) |-> $past(deviceReset, 5))
        else $error("reset released early");
    addr_latch_a: assert property ($fell(deviceReset) && addrStrapLsb == $past(addrStrapLsb, 2)
        && addrStrapMsb == $past(addrStrapMsb, 2) |-> slaveAddrLow == {addrStrapMsb, addrStrapLsb})
        else $error("address not latched");
    irq_follow_a: assert property (!deviceReset && !$past(deviceReset)
        |-> irqOrDataReady_n == !$past(irqSelPen ? penTouchIrq : dataReady))
        else $error("irq not active low of source");
    spike_ignore_a: assert property (!deviceReset && !ctrlByte1Wr && $rose(resetPin_n)
        && $past(resetPin_n, 2) |=> !deviceReset[*4]) else $error("spike caused reset");
    pin_qualify_a: assert property (lowCnt_ff == 10'(MIN_CYC + 12) |-> deviceReset)
        else $error("long pin low not taken");
endmodule : tcr_reset_props
bind tcr_reset_logic tcr_reset_props #(.MIN_CYC(MIN_CYC)) chk_u (.ref_clk, .rst_n, .resetPin_n,
    .addrStrapLsb, .addrStrapMsb, .ctrlByte1Wr, .ctrlByte1Data, .dataReady, .penTouchIrq,
    .irqSelPen, .deviceReset, .irqOrDataReady_n, .slaveAddrLow, .resultReg);

// ---- tcr_host_model.sv ----
// Host model driving the reset pin and control byte writes
`timescale 1ns/10ps
module tcr_host_model
    import tcr_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   irqOrDataReady_n,
    output logic                        resetPin_n,
    output logic                        ctrlByte1Wr,
    output logic [CTRL_BYTE_W-1:0]      ctrlByte1Data
);
    logic irqSeen;
    initial
    begin
        resetPin_n = 1'b1;
        ctrlByte1Wr = 1'b0;
        ctrlByte1Data = 8'h5a;
    end
    // Line only sampled, never driven
    always @(posedge ref_clk) irqSeen <= irqOrDataReady_n;
    // Widths between the reject and accept limits are never requested
    task automatic pinLow(input int n);
        @(posedge ref_clk) resetPin_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        resetPin_n <= 1'b1;
    endtask : pinLow
    task automatic ctrlWrite(input logic [CTRL_BYTE_W-1:0] d);
        @(posedge ref_clk);
        ctrlByte1Wr <= 1'b1;
        ctrlByte1Data <= d;
        @(posedge ref_clk);
        ctrlByte1Wr <= 1'b0;
        ctrlByte1Data <= ~d;
    endtask : ctrlWrite
endmodule : tcr_host_model

// ---- tcr_reset_logic_tb.sv ----
// Self-checking bench of the reset sequencer
`timescale 1ns/10ps
module tcr_reset_logic_tb;
    import tcr_pkg::*;
    localparam int MIN = 20;
    logic       ref_clk, rst_n, resetPin_n, ctrlByte1Wr, dataReady, penTouchIrq, irqSelPen;
    logic       resultWr, addrStrapLsb, addrStrapMsb, deviceReset, irqOrDataReady_n;
    logic [7:0] ctrlByte1Data;
    logic [1:0] slaveAddrLow;
    logic [15:0] resultData, resultReg;
    int         fail_count, compares, seed, cyc;
    tcr_reset_logic #(.MIN_CYC(MIN)) dut_u (.ref_clk, .rst_n, .resetPin_n, .addrStrapLsb,
        .addrStrapMsb, .ctrlByte1Wr, .ctrlByte1Data, .dataReady, .penTouchIrq, .irqSelPen,
        .resultWr, .resultData, .deviceReset, .irqOrDataReady_n, .slaveAddrLow, .resultReg);
    tcr_host_model host_u (.ref_clk, .irqOrDataReady_n, .resetPin_n, .ctrlByte1Wr,
        .ctrlByte1Data);
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic expIrq(input logic sel, input logic pen, input logic dr);
        return ~(sel ? pen : dr);
    endfunction : expIrq
    task automatic test_done;
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // Bounded wait, so a stuck reset fails instead of hanging
    task automatic waitRst(input logic v, input int n, input string nm);
        int k = 0;
        while (deviceReset !== v && k < n)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk(nm, 16'(deviceReset), 16'(v));
    endtask : waitRst
    task automatic quiet(input int n, input string nm);
        logic hi = 1'b0;
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            hi |= deviceReset;
        end
        chk(nm, 16'(hi), 16'h0000);
    endtask : quiet
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        seed = 67931;
        {rst_n, addrStrapLsb, addrStrapMsb, dataReady, penTouchIrq, irqSelPen, resultWr} = 7'h00;
        resultData = 16'h0000;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("resultReg", resultReg, 16'h0000);
        chk("irq", 16'(irqOrDataReady_n), 16'h0001);
        waitRst(1'b0, 10, "release");
        repeat (100)
        begin
            @(posedge ref_clk);
            {irqSelPen, penTouchIrq, dataReady} <= 3'($random(seed));
            resultWr <= 1'b1;
            resultData <= 16'($random(seed));
            @(posedge ref_clk);
            #1;
            chk("irq", 16'(irqOrDataReady_n), 16'(expIrq(irqSelPen, penTouchIrq, dataReady)));
            chk("result", resultReg, resultData);
        end
        resultWr <= 1'b0;
        host_u.ctrlWrite(8'($random(seed)) | 8'h02);
        waitRst(1'b1, 3, "soft");
        chk("cleared", resultReg, 16'h0000);
        waitRst(1'b0, 10, "soft end");
        host_u.ctrlWrite(8'($random(seed)) & 8'hfd);
        quiet(8, "bit clear");
        host_u.pinLow(1);
        quiet(MIN + 12, "spike");
        host_u.pinLow(MIN / 2 - 4);
        quiet(MIN + 12, "short");
        for (int i = 0; i < 4; i++)
        begin
            {addrStrapMsb, addrStrapLsb} <= 2'(i);
            host_u.pinLow(MIN + 14);
            waitRst(1'b1, 2, "pin");
            waitRst(1'b0, 12, "pin end");
            chk("addr", 16'(slaveAddrLow), 16'(i));
        end
        test_done();
    end
endmodule : tcr_reset_logic_tb
